// ===== include/shc_defines.svh
`ifndef SHC_DEFINES_SVH
`define SHC_DEFINES_SVH

// Header values as {bit0, bit1} of the block
`define SHC_HDR_ONE 2'h1
`define SHC_HDR_ZERO 2'h2
`define SHC_PAY_LSB 2
`define SHC_PAY_MSB 65

// Multiblock geometry
`define SHC_MB_LAST 5'h1f
`define SHC_MB_FILL 6'h20

// Header stream layout, bit 0 from the first block
`define SHC_END_OF_MULTIBLOCK_PATTERN_MSB 31
`define SHC_END_OF_MULTIBLOCK_PATTERN_LSB 27
`define SHC_END_OF_MULTIBLOCK_PATTERN_PAT 5'h10
`define SHC_END_OF_EXTENDED_MULTIBLOCK_FLAG_BIT 22
`define SHC_PILOT_ONES 32'h00a8_8888
`define SHC_CRC_GROUPS 4
`define SHC_CRC_GRP_BITS 3
`define SHC_CRC_GRP_STRIDE 4
`define SHC_CRC_POLY 12'h987

// Header stream modes
`define SHC_MODE_CRC12 2'h0

// Alignment counts, in blocks; SHC_FEC_CONFIRM in multiblocks
`define SHC_LOCK_CNT 7'h40
`define SHC_BAD_CNT 5'h10
`define SHC_SLIP_HOLD 3'h4
`define SHC_FEC_CONFIRM 3'h4
`define SHC_CRC_MIN_LAT 7'h2e
`define SHC_AGE_MAX 7'h7f

`endif

// ===== include/shc_pkg.sv
package shc_pkg;
  typedef enum logic [1:0] {SHC_BLK_SEARCH, SHC_BLK_LOCKED} shc_blk_state_e;
  typedef enum logic [1:0] {SHC_MB_HUNT, SHC_MB_CONFIRM, SHC_MB_LOCK}
    shc_mb_state_e;
  typedef logic [63:0] shc_payload_t;
  // {end of extended multiblock, end of multiblock, first block, payload}
  typedef logic [66:0] shc_beat_t;
  typedef logic [31:0] shc_stream_t;
  typedef logic [11:0] shc_crc_t;
endpackage : shc_pkg

// ===== rtl/shc_buf2.sv
`timescale 1ns/1ps
`default_nettype none

module shc_buf2 (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire shc_pkg::shc_beat_t in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output var shc_pkg::shc_beat_t out_data
);
  import shc_pkg::*;

  logic [1:0] cnt;
  logic [1:0] next_cnt;
  shc_beat_t ent1;
  shc_beat_t next_ent0;
  shc_beat_t next_ent1;
  logic push;
  logic pop;

  assign in_ready = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb
  begin
    next_cnt = cnt;
    next_ent0 = out_data;
    next_ent1 = ent1;
    if (push && !pop)
    begin
      next_cnt = cnt + 2'h1;
      if (cnt == 2'h0)
        next_ent0 = in_data;
      else
        next_ent1 = in_data;
    end
    else if (pop && !push)
    begin
      next_cnt = cnt - 2'h1;
      next_ent0 = ent1;
    end
    else if (pop && push)
    begin
      if (cnt == 2'h1)
        next_ent0 = in_data;
      else
      begin
        next_ent0 = ent1;
        next_ent1 = in_data;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt <= 2'h0;
      out_data <= '0;
      ent1 <= '0;
    end
    else
    begin
      cnt <= next_cnt;
      out_data <= next_ent0;
      ent1 <= next_ent1;
    end
  end
endmodule : shc_buf2

`default_nettype wire

// ===== rtl/shc_rx.sv
`timescale 1ns/1ps
`default_nettype none
`include "shc_defines.svh"

// Function
// R1 - Transmitted block header bits always differ: 01 or 10.
// R2 - Find block boundary where a header transition repeats every 66 bits.
// R3 - A 00 or 11 header at the boundary flags possible alignment loss.
// R4 - After repeated bad headers ask for SYSREF and restart the search.
// R5 - Header 01 carries a one, header 10 carries a zero.
// R6 - Header bits of one multiblock gather in order into a 32-bit word.
// R7 - Stream carries parity or error correction; no short parity, no commands.
// R8 - Last five bits of every stream word are 00001.
// R9 - In parity mode 00001 appears only at the word end.
// R10 - In correction mode confirm the end position over several multiblocks.
// R11 - Stream bit 22 is one in the last multiblock of an extended one.
// R12 - Twelve parity bits cover the scrambled payload of all 32 blocks.
// R13 - Parity of one multiblock travels in the next multiblock's stream.
// R14 - Recompute parity, compare with the next word, report a mismatch.
// R15 - An error in a multiblock's first bit shows no sooner than 46 blocks.
// R16 - Mode select value zero means 12-bit parity mode.
// R17 - In parity mode all seven command positions are zero.
// R18 - Fixed ones make the end unique: lock after one multiblock.
// R19 - Payload is scrambled, header sits at bits 0 to 1 of 66.
// R20 - An extended multiblock holds E multiblocks, E may be one.
// R21 - SYSREF resets the local extended multiblock clock phase.
// R22 - Lock after a count of good headers, drop after a count of bad.
// R23 - Parity bit placement follows the standard 12-bit parity mapping.
module shc_rx (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Blocks from the gearbox
  input wire logic [65:0] rx_block,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic rx_slip,
  // SYSREF
  input wire logic sysref,
  output logic sysref_request,
  // Configuration
  input wire logic [1:0] header_stream_mode_select,
  input wire logic [4:0] emb_len_m1,
  // Payload stream
  output var shc_pkg::shc_payload_t out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic out_mb_start,
  output logic end_of_multiblock_pattern,
  output logic end_of_extended_multiblock_flag,
  // Status
  output logic block_locked,
  output logic multiblock_locked,
  output logic header_error,
  output logic crc_error,
  output var shc_pkg::shc_stream_t header_stream_word,
  output logic header_stream_valid,
  output logic local_extended_multiblock_clock
);
  import shc_pkg::*;

  function automatic shc_crc_t crc_step(input shc_crc_t c_in,
                                        input shc_payload_t d);
    shc_crc_t c;
    logic fb;
    c = c_in;
    for (int i = 0; i < 64; i++)
    begin
      fb = c[11] ^ d[i];
      c = {c[10:0], 1'b0};
      if (fb)
        c = c ^ `SHC_CRC_POLY;
    end
    return c;
  endfunction : crc_step

  // Parity word carried in a stream word, CRC[11] in bit 0
  function automatic shc_crc_t crc_extract(input shc_stream_t w);
    shc_crc_t c;
    c = '0;
    for (int g = 0; g < `SHC_CRC_GROUPS; g++)
      for (int k = 0; k < `SHC_CRC_GRP_BITS; k++)
        c[11 - (g * `SHC_CRC_GRP_BITS + k)] = w[g * `SHC_CRC_GRP_STRIDE + k];
    return c;
  endfunction : crc_extract

  logic sysref_meta;
  logic sysref_sync;
  logic sysref_last;
  logic sysref_edge;
  logic accept;
  logic [1:0] hdr;
  logic hdr_ok;
  logic hdr_bit;
  shc_payload_t payload;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sysref_meta <= 1'b0;
      sysref_sync <= 1'b0;
      sysref_last <= 1'b0;
    end
    else
    begin
      sysref_meta <= sysref;
      sysref_sync <= sysref_meta;
      sysref_last <= sysref_sync;
    end
  end

  assign sysref_edge = sysref_sync & ~sysref_last;
  assign accept = rx_valid & rx_ready;
  assign hdr = {rx_block[0], rx_block[1]};
  assign hdr_ok = (hdr == `SHC_HDR_ONE) || (hdr == `SHC_HDR_ZERO); // see R1
  assign hdr_bit = (hdr == `SHC_HDR_ONE); // see R5
  assign payload = rx_block[`SHC_PAY_MSB:`SHC_PAY_LSB]; // see R19

  // Block alignment
  shc_blk_state_e blk_state;
  shc_blk_state_e next_blk_state;
  logic [6:0] good_cnt;
  logic [6:0] next_good_cnt;
  logic [4:0] bad_cnt;
  logic [4:0] next_bad_cnt;
  logic [2:0] hold_cnt;
  logic [2:0] next_hold_cnt;
  logic next_slip;
  logic next_sysreq;
  logic next_hdr_err;

  always_comb
  begin
    next_blk_state = blk_state;
    next_good_cnt = good_cnt;
    next_bad_cnt = bad_cnt;
    next_hold_cnt = hold_cnt;
    next_slip = 1'b0;
    next_sysreq = 1'b0;
    next_hdr_err = 1'b0;
    if (accept)
    begin
      case (blk_state)
        SHC_BLK_SEARCH:
        begin
          if (hold_cnt != 3'h0)
            next_hold_cnt = hold_cnt - 3'h1;
          else if (hdr_ok)
          begin
            if (good_cnt == `SHC_LOCK_CNT - 7'h01) // see R22
            begin
              next_blk_state = SHC_BLK_LOCKED;
              next_good_cnt = 7'h00;
              next_bad_cnt = 5'h00;
            end
            else
              next_good_cnt = good_cnt + 7'h01;
          end
          else
          begin
            // Shift the candidate boundary by one bit
            next_slip = 1'b1; // see R2
            next_good_cnt = 7'h00;
            next_hold_cnt = `SHC_SLIP_HOLD;
          end
        end
        SHC_BLK_LOCKED:
        begin
          if (hdr_ok)
            next_bad_cnt = 5'h00;
          else
          begin
            next_hdr_err = 1'b1; // see R3
            if (bad_cnt == `SHC_BAD_CNT - 5'h01) // see R22
            begin
              next_blk_state = SHC_BLK_SEARCH;
              next_bad_cnt = 5'h00;
              next_sysreq = 1'b1; // see R4
            end
            else
              next_bad_cnt = bad_cnt + 5'h01;
          end
        end
        default:
          next_blk_state = SHC_BLK_SEARCH;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      blk_state <= SHC_BLK_SEARCH;
      good_cnt <= 7'h00;
      bad_cnt <= 5'h00;
      hold_cnt <= 3'h0;
      rx_slip <= 1'b0;
      sysref_request <= 1'b0;
      header_error <= 1'b0;
    end
    else
    begin
      blk_state <= next_blk_state;
      good_cnt <= next_good_cnt;
      bad_cnt <= next_bad_cnt;
      hold_cnt <= next_hold_cnt;
      rx_slip <= next_slip;
      sysref_request <= next_sysreq;
      header_error <= next_hdr_err;
    end
  end

  assign block_locked = (blk_state == SHC_BLK_LOCKED);

  // Multiblock alignment and parity check
  shc_mb_state_e mb_state;
  shc_mb_state_e next_mb_state;
  shc_stream_t sh_sr;
  shc_stream_t next_sh;
  shc_stream_t next_sh_word;
  logic [4:0] blk_cnt;
  logic [4:0] next_blk_cnt;
  logic [5:0] fill_cnt;
  logic [5:0] next_fill_cnt;
  logic [2:0] confirm_cnt;
  logic [2:0] next_confirm_cnt;
  shc_crc_t crc_acc;
  shc_crc_t next_crc_acc;
  shc_crc_t crc_sum;
  shc_crc_t crc_prev;
  shc_crc_t next_crc_prev;
  logic prev_ok;
  logic next_prev_ok;
  logic next_crc_err;
  logic next_sh_valid;
  logic crc_mode;
  logic end_seen;
  logic word_ok;

  assign crc_mode = (header_stream_mode_select == `SHC_MODE_CRC12); // see R16
  assign next_sh = {hdr_bit, sh_sr[31:1]}; // see R6
  assign crc_sum = crc_step(crc_acc, payload); // see R12
  assign end_seen = (next_sh[`SHC_END_OF_MULTIBLOCK_PATTERN_MSB:`SHC_END_OF_MULTIBLOCK_PATTERN_LSB] == `SHC_END_OF_MULTIBLOCK_PATTERN_PAT)
                    && (fill_cnt >= `SHC_MB_FILL - 6'h01); // see R8
  // Fixed ones make the end pattern unique in parity mode
  assign word_ok = end_seen && (!crc_mode ||
                   ((next_sh & `SHC_PILOT_ONES) == `SHC_PILOT_ONES)); // see R9

  always_comb
  begin
    next_mb_state = mb_state;
    next_blk_cnt = blk_cnt;
    next_fill_cnt = fill_cnt;
    next_confirm_cnt = confirm_cnt;
    next_crc_acc = crc_acc;
    next_crc_prev = crc_prev;
    next_prev_ok = prev_ok;
    next_crc_err = 1'b0;
    next_sh_valid = 1'b0;
    next_sh_word = header_stream_word;
    if (!block_locked)
    begin
      next_mb_state = SHC_MB_HUNT;
      next_fill_cnt = 6'h00;
    end
    else if (accept && !hdr_ok)
    begin
      next_mb_state = SHC_MB_HUNT;
      next_fill_cnt = 6'h00;
    end
    else if (accept)
    begin
      if (fill_cnt != `SHC_MB_FILL)
        next_fill_cnt = fill_cnt + 6'h01;
      case (mb_state)
        SHC_MB_HUNT:
        begin
          if (word_ok)
          begin
            next_blk_cnt = 5'h00;
            next_crc_acc = '0;
            next_prev_ok = 1'b0;
            next_confirm_cnt = 3'h0;
            next_mb_state = crc_mode ? SHC_MB_LOCK : SHC_MB_CONFIRM; // see R18
          end
        end
        SHC_MB_CONFIRM:
        begin
          if (blk_cnt == `SHC_MB_LAST)
          begin
            next_blk_cnt = 5'h00;
            if (!word_ok)
              next_mb_state = SHC_MB_HUNT;
            else if (confirm_cnt == `SHC_FEC_CONFIRM - 3'h1) // see R10
            begin
              next_mb_state = SHC_MB_LOCK;
              next_crc_acc = '0;
              next_prev_ok = 1'b0;
            end
            else
              next_confirm_cnt = confirm_cnt + 3'h1;
          end
          else
            next_blk_cnt = blk_cnt + 5'h01;
        end
        SHC_MB_LOCK:
        begin
          if (blk_cnt == `SHC_MB_LAST)
          begin
            next_blk_cnt = 5'h00;
            next_sh_word = next_sh;
            next_sh_valid = 1'b1;
            if (!word_ok)
              next_mb_state = SHC_MB_HUNT;
            else
            begin
              // Parity of the previous multiblock arrives in this word
              if (crc_mode && prev_ok && crc_extract(next_sh) != crc_prev)
                next_crc_err = 1'b1; // see R13 see R14 see R23
              next_crc_prev = crc_sum;
              next_prev_ok = 1'b1;
              next_crc_acc = '0;
            end
          end
          else
          begin
            next_blk_cnt = blk_cnt + 5'h01;
            next_crc_acc = crc_sum;
          end
        end
        default:
          next_mb_state = SHC_MB_HUNT;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mb_state <= SHC_MB_HUNT;
      sh_sr <= '0;
      blk_cnt <= 5'h00;
      fill_cnt <= 6'h00;
      confirm_cnt <= 3'h0;
      crc_acc <= '0;
      crc_prev <= '0;
      prev_ok <= 1'b0;
      crc_error <= 1'b0;
      header_stream_word <= '0;
      header_stream_valid <= 1'b0;
    end
    else
    begin
      mb_state <= next_mb_state;
      if (accept)
        sh_sr <= next_sh;
      blk_cnt <= next_blk_cnt;
      fill_cnt <= next_fill_cnt;
      confirm_cnt <= next_confirm_cnt;
      crc_acc <= next_crc_acc;
      crc_prev <= next_crc_prev;
      prev_ok <= next_prev_ok;
      crc_error <= next_crc_err;
      header_stream_word <= next_sh_word;
      header_stream_valid <= next_sh_valid;
    end
  end

  assign multiblock_locked = (mb_state == SHC_MB_LOCK);

  // Local extended multiblock clock
  logic [4:0] local_extended_multiblock_clock_blk;
  logic [4:0] next_local_extended_multiblock_clock_blk;
  logic [4:0] local_extended_multiblock_clock_mb;
  logic [4:0] next_local_extended_multiblock_clock_mb;
  logic next_local_extended_multiblock_clock_pulse;

  always_comb
  begin
    next_local_extended_multiblock_clock_blk = local_extended_multiblock_clock_blk;
    next_local_extended_multiblock_clock_mb = local_extended_multiblock_clock_mb;
    next_local_extended_multiblock_clock_pulse = 1'b0;
    if (sysref_edge)
    begin
      next_local_extended_multiblock_clock_blk = 5'h00; // see R21
      next_local_extended_multiblock_clock_mb = 5'h00;
    end
    else if (accept)
    begin
      if (local_extended_multiblock_clock_blk == `SHC_MB_LAST)
      begin
        next_local_extended_multiblock_clock_blk = 5'h00;
        if (local_extended_multiblock_clock_mb >= emb_len_m1) // see R20
        begin
          next_local_extended_multiblock_clock_mb = 5'h00;
          next_local_extended_multiblock_clock_pulse = 1'b1;
        end
        else
          next_local_extended_multiblock_clock_mb = local_extended_multiblock_clock_mb + 5'h01;
      end
      else
        next_local_extended_multiblock_clock_blk = local_extended_multiblock_clock_blk + 5'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      local_extended_multiblock_clock_blk <= 5'h00;
      local_extended_multiblock_clock_mb <= 5'h00;
      local_extended_multiblock_clock <= 1'b0;
    end
    else
    begin
      local_extended_multiblock_clock_blk <= next_local_extended_multiblock_clock_blk;
      local_extended_multiblock_clock_mb <= next_local_extended_multiblock_clock_mb;
      local_extended_multiblock_clock <= next_local_extended_multiblock_clock_pulse;
    end
  end

  // Payload into the two-entry buffer
  logic push;
  logic beat_end_of_multiblock_pattern;
  shc_beat_t beat_in;
  shc_beat_t beat_out;

  assign push = accept && block_locked && hdr_ok && multiblock_locked;
  assign beat_end_of_multiblock_pattern = (blk_cnt == `SHC_MB_LAST);
  assign beat_in = {beat_end_of_multiblock_pattern & next_sh[`SHC_END_OF_EXTENDED_MULTIBLOCK_FLAG_BIT], // see R11
                    beat_end_of_multiblock_pattern, (blk_cnt == 5'h00), payload};

  shc_buf2 u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(rx_ready),
    .in_data(beat_in),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(beat_out)
  );

  assign out_data = beat_out[63:0];
  assign out_mb_start = beat_out[64];
  assign end_of_multiblock_pattern = beat_out[65];
  assign end_of_extended_multiblock_flag = beat_out[66];

  // Blocks since multiblock lock, for latency checking
  logic [6:0] lock_age;
  always_ff @(posedge clk)
  begin
    if (!rst_n || !multiblock_locked)
      lock_age <= 7'h00;
    else if (accept && lock_age != `SHC_AGE_MAX)
      lock_age <= lock_age + 7'h01;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_lose_lock;
    blk_state == SHC_BLK_LOCKED && accept && !hdr_ok &&
      bad_cnt == `SHC_BAD_CNT - 5'h01;
  endsequence
  sequence s_mb_end_mismatch;
    mb_state == SHC_MB_LOCK && accept && hdr_ok && block_locked &&
      blk_cnt == `SHC_MB_LAST && word_ok && crc_mode && prev_ok &&
      crc_extract(next_sh) != crc_prev;
  endsequence

  a_slip_bad_header: assert property ( // see R2
    (blk_state == SHC_BLK_SEARCH && hold_cnt == 3'h0 && accept && !hdr_ok)
      |=> rx_slip ##1 !rx_slip)
    else $error("no single slip after a bad header in search");
  a_header_error_flag: assert property ( // see R3
    (block_locked && accept && !hdr_ok) |=> header_error)
    else $error("bad header while locked not flagged");
  a_lose_lock_drop: assert property ( // see R22 see R4
    s_lose_lock |=> (!block_locked && sysref_request))
    else $error("lock not dropped with sysref request");
  a_stream_bit_order: assert property ( // see R5 see R6
    header_stream_valid |-> header_stream_word[31] == $past(hdr_bit) &&
      header_stream_word[30:0] == $past(sh_sr[31:1]))
    else $error("stream word does not hold header bits in order");
  a_fec_confirm_path: assert property ( // see R10
    ($rose(multiblock_locked) && !crc_mode) |->
      $past(mb_state) == SHC_MB_CONFIRM)
    else $error("correction mode locked without confirmation");
  a_end_of_extended_multiblock_flag_last_block: assert property ( // see R11
    (out_valid && end_of_extended_multiblock_flag) |->
      end_of_multiblock_pattern)
    else $error("extended end flag off the last block");
  a_crc_mismatch: assert property ( // see R14
    s_mb_end_mismatch |=> crc_error ##1 !crc_error)
    else $error("parity mismatch not reported");
  a_crc_latency: assert property ( // see R15
    crc_error |-> $past(lock_age) >= `SHC_CRC_MIN_LAT)
    else $error("parity error earlier than 46 blocks");
  a_one_mb_lock: assert property ( // see R18
    (mb_state == SHC_MB_HUNT && block_locked && accept && hdr_ok &&
      word_ok && crc_mode) |=> multiblock_locked)
    else $error("parity mode needs more than one multiblock");
  a_sysref_phase: assert property ( // see R21
    sysref_edge |=> (local_extended_multiblock_clock_blk == 5'h00 && local_extended_multiblock_clock_mb == 5'h00))
    else $error("sysref did not reset the extended multiblock clock");
endmodule : shc_rx

`default_nettype wire

// ===== verif/shc_tx_model.sv
`timescale 1ns/1ps
`default_nettype none

module shc_tx_model (
  // Clock, reset, SYSREF
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sync,
  // Block lane
  output logic [65:0] blk = '0,
  output logic vld = 1'b0,
  input wire logic rdy,
  // Control: 1 good blocks, 2 bad headers up to nbad
  input wire logic [1:0] cmd,
  input wire logic [4:0] nbad,
  input wire logic [4:0] e_m1,
  input wire logic [31:0] rnd
);
  import shc_pkg::*;
  shc_beat_t pay_q[$];
  shc_stream_t wrd_q[$];
  logic err_q[$];
  int blk_i = 0;
  int bad_n = 0;
  int n_local_extended_multiblock_clock = 0;
  int err_mb = 5;
  int fwd_mb = 4;
  logic bad = 1'b0;
  shc_crc_t crc = '0;
  shc_crc_t crc_prev = '0;
  shc_stream_t word = '0;
  shc_payload_t clean = '0;

  function automatic shc_crc_t crc_step(shc_crc_t c, shc_payload_t d);
    for (int i = 0; i < 64; i++)
      c = {c[10:0], 1'b0} ^ ((c[11] ^ d[i]) ? 12'h987 : 12'h000);
    return c;
  endfunction : crc_step

  function automatic shc_stream_t mk_word(shc_crc_t c, logic eo);
    shc_stream_t w;
    w = 32'h8000_0000 | 32'h00a8_8888;
    w[22] = eo;
    for (int g = 0; g < 4; g++)
      for (int b = 0; b < 3; b++)
        w[4 * g + b] = c[11 - 3 * g - b];
    return w;
  endfunction : mk_word

  task automatic take();
    int pos;
    int mb;
    pos = blk_i % 32;
    mb = blk_i / 32;
    if (pos == 31 && mb % (e_m1 + 1) == e_m1)
      n_local_extended_multiblock_clock++;
    if (!bad && mb >= fwd_mb)
      pay_q.push_back({word[22] && pos == 31, pos == 31, pos == 0,
        blk[65:2]});
    if (!bad)
      crc = crc_step(pos == 0 ? 12'h000 : crc, clean);
    if (!bad && pos == 31 && mb >= fwd_mb)
    begin
      wrd_q.push_back(word);
      err_q.push_back(mb == err_mb + 1);
    end
    if (pos == 31)
      crc_prev = crc;
    blk_i++;
  endtask : take

  task automatic build();
    int pos;
    shc_payload_t p;
    pos = blk_i % 32;
    if (pos == 0)
      word = mk_word(crc_prev, (blk_i / 32) % (e_m1 + 1) == e_m1);
    p = {rnd, rnd ^ 32'hc3a5_96f0};
    clean = p;
    // Flip of the first payload bit, parity kept clean
    if (blk_i / 32 == err_mb && pos == 0)
      p[0] = ~p[0];
    bad = (cmd == 2'h2);
    bad_n += bad;
    blk <= {p, bad ? {2{rnd[1]}} : (word[pos] ? 2'b10 : 2'b01)};
  endtask : build

  always @(posedge clk)
  begin
    if (!rst_n || sync)
    begin
      vld <= 1'b0;
      bad_n = 0;
      blk_i = 0;
      crc = '0;
      crc_prev = '0;
    end
    else
    begin
      if (vld && rdy)
        take();
      if (cmd != 2'h2)
        bad_n = 0;
      if (!(vld && !rdy))
      begin
        if (rnd[0] && (cmd == 2'h1 || (cmd == 2'h2 && bad_n < nbad)))
        begin
          build();
          vld <= 1'b1;
        end
        else
        begin
          // Released lane shows no stale block
          vld <= 1'b0;
          blk <= ~blk;
        end
      end
    end
  end
endmodule : shc_tx_model

`default_nettype wire

// ===== verif/shc_rx_tb.sv
`timescale 1ns/1ps
`default_nettype none

module shc_rx_tb;
  import shc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sysref = 1'b0;
  logic out_ready = 1'b0;
  logic hold = 1'b0;
  logic fec = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [1:0] cmd = 2'h0;
  logic [4:0] nbad = 5'h00;
  logic [4:0] e_m1 = 5'h01;
  logic [31:0] rnd = 32'h0000_3dd3;
  logic [65:0] rx_block;
  logic rx_valid, rx_ready, rx_slip, sreq, out_valid, mb_start;
  logic mb_end, emb_end, blk_lock, mb_lock, hdr_err, crc_err;
  logic hs_valid, tick;
  shc_payload_t out_data;
  shc_stream_t hs_word;
  int n_fail = 0;
  int n_checks = 0;
  int n_slip = 0, n_hdr = 0, n_sreq = 0, n_crc = 0, n_tick = 0;

  always #4 clk = ~clk;

  shc_tx_model m (
    .clk(clk), .rst_n(rst_n), .sync(sysref), .blk(rx_block),
    .vld(rx_valid), .rdy(rx_ready), .cmd(cmd), .nbad(nbad),
    .e_m1(e_m1), .rnd(rnd)
  );

  shc_rx dut_u (
    .clk(clk), .rst_n(rst_n), .rx_block(rx_block), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_slip(rx_slip), .sysref(sysref),
    .sysref_request(sreq), .header_stream_mode_select(mode),
    .emb_len_m1(e_m1), .out_data(out_data), .out_valid(out_valid),
    .out_ready(out_ready), .out_mb_start(mb_start),
    .end_of_multiblock_pattern(mb_end),
    .end_of_extended_multiblock_flag(emb_end),
    .block_locked(blk_lock), .multiblock_locked(mb_lock),
    .header_error(hdr_err), .crc_error(crc_err),
    .header_stream_word(hs_word), .header_stream_valid(hs_valid),
    .local_extended_multiblock_clock(tick)
  );

  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic check(string what, logic [66:0] seen, logic [66:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic bring_up();
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // One bad header while searching
    nbad <= 5'h01;
    cmd <= 2'h2;
    @(posedge clk iff m.bad_n == 1 && !m.vld);
    cmd <= 2'h0;
    sysref <= 1'b1;
    repeat (2) @(posedge clk);
    sysref <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : bring_up

  task automatic go_until(int n);
    cmd <= 2'h1;
    @(posedge clk iff m.blk_i >= n);
  endtask : go_until

  // Random stalls of the payload sink
  always @(posedge clk)
  begin
    rnd <= xs(rnd);
    out_ready <= !hold && (rnd[2] || rnd[3]);
  end

  always @(posedge clk)
  begin
    n_slip += (rx_slip === 1'b1);
    n_hdr += (hdr_err === 1'b1);
    n_sreq += (sreq === 1'b1);
    n_crc += (crc_err === 1'b1);
    n_tick += (tick === 1'b1);
    if (out_valid === 1'b1 && out_ready && !fec)
      check("beat", {emb_end, mb_end, mb_start, out_data},
        m.pay_q.size() > 0 ? m.pay_q.pop_front() : 67'h0);
    if (hs_valid === 1'b1 && !fec)
    begin
      check("word", 67'(hs_word), 67'(m.wrd_q.pop_front()));
      check("parity", 67'(crc_err), 67'(m.err_q.pop_front()));
    end
  end

  initial
  begin
    bring_up();
    go_until(160);
    hold <= 1'b1;
    @(posedge clk iff rx_ready === 1'b0);
    check("full valid", 67'(out_valid), 67'h1);
    repeat (8) @(posedge clk);
    hold <= 1'b0;
    go_until(256);
    check("block lock", 67'(blk_lock), 67'h1);
    check("mb lock", 67'(mb_lock), 67'h1);
    nbad <= 5'h10;
    cmd <= 2'h2;
    @(posedge clk iff m.bad_n == 16 && !m.vld);
    repeat (8) @(posedge clk);
    check("lock lost", 67'(blk_lock), 67'h0);
    check("header errors", 67'(n_hdr), 67'd16);
    check("sysref requests", 67'(n_sreq), 67'd1);
    check("slips", 67'(n_slip), 67'd1);
    check("beats left", 67'(m.pay_q.size()), 67'h0);
    check("words left", 67'(m.wrd_q.size()), 67'h0);
    fec <= 1'b1;
    mode <= 2'h1;
    // Single multiblock per extended multiblock
    e_m1 <= 5'h00;
    bring_up();
    go_until(160);
    check("early lock", 67'(mb_lock), 67'h0);
    go_until(352);
    // Let the last clock pulse land before counting
    cmd <= 2'h0;
    repeat (4) @(posedge clk);
    check("late lock", 67'(mb_lock), 67'h1);
    check("parity errors", 67'(n_crc), 67'd1);
    check("emb ticks", 67'(n_tick), 67'(m.n_local_extended_multiblock_clock));
    end_sim();
  end

  // Both phases need about 2000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end
endmodule : shc_rx_tb

`default_nettype wire
